/* File: src/id_health_params.svh */
// Offsets, field positions and reset values of the identity and health registers.
// Assumes inclusion by the register bank and its package users only.
`ifndef ID_HEALTH_PARAMS_SVH
`define ID_HEALTH_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_MAC_ADDRESS_LOW      16'h1002
`define OFS_MAC_ADDRESS_HIGH     16'h1003
`define OFS_DIE_WAFER_POSITION   16'h1004
`define OFS_CONFIG_MEMORY_HEALTH 16'h1005

// ----------------------------------------
// Health register fields
// ----------------------------------------
`define HB_RED_WARN    15
`define HB_RED_ERR     14
`define HB_YELLOW_WARN 13
`define HB_YELLOW_ERR  12
`define HB_GREEN_WARN  11
`define HB_GREEN_ERR   10
`define HEALTH_RESET   16'h0000

// ----------------------------------------
// Wafer position fields
// ----------------------------------------
`define WAFER_Y_MSB 14
`define WAFER_Y_LSB 8
`define WAFER_X_MSB 6
`define WAFER_X_LSB 0

// ----------------------------------------
// Factory memory layout and code word
// ----------------------------------------
`define NVM_IDX_MAC_LOW  5'h00
`define NVM_IDX_MAC_HIGH 5'h01
`define NVM_IDX_WAFER    5'h02
`define NVM_IDX_RED_BASE 5'h03
`define ECC_CW_BITS      22
`define DATA_RESET       16'h0000

`endif

/* File: src/id_health_pkg.sv */
// Types shared by the identity and configuration memory health bank.
// Assumes nothing of its surroundings.
`default_nettype none

package id_health_pkg;

    typedef enum logic [1:0] { ZONE_GREEN, ZONE_YELLOW, ZONE_RED } nvm_zone_t;

    typedef enum { ST_ADDR, ST_DATA, ST_DONE } load_state_t;

    typedef struct packed {
        logic [15:0] data;
        logic        single;
        logic        double;
    } ecc_result_t;

endpackage : id_health_pkg

`default_nettype wire

/* File: src/device_identity_config_memory_health_regs.sv */
// Read-only identity and configuration memory health register bank.
// Assumes a factory memory with one-cycle read latency on the core clock,
// and a register read port driven by the serial register engine on clk.
//
// How it works
// - Low identifier register returns MAC bits 15:0
// - High register returns bits 23:16, upper zero
// - Full MAC is OUI plus 24 bits
// - Wafer Y at 14:8, X at 6:0
// - Factory memory has no write path
// - ECC corrects single, detects double errors
// - Bit 15: red zone corrected single error
// - Bit 14: red zone uncorrectable error
// - Bit 13: yellow zone corrected single error
// - Bit 12: yellow uncorrectable, identifier invalid
// - Bit 11: green zone corrected single error
// - Bit 10: green uncorrectable, trace lost
// - Bits 9:0 reserved, read zero here
// - Memory split into green, yellow, red
// - All logic on one reference clock
// - Clock output follows enable, else low
`timescale 1ns/1ps
`default_nettype none
`include "id_health_params.svh"

module device_identity_config_memory_health_regs
    import id_health_pkg::*;
#(
    parameter int RED_WORDS = 4
) (
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    // Register read port
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_addr,
    output logic      [15:0] reg_rdata,
    output logic             reg_rvalid,
    output logic             reg_err,
    // Factory memory, read only
    output logic             nvm_rd,
    output logic      [4:0]  nvm_addr,
    input  wire logic [21:0] nvm_cw,
    // Corrected configuration words for the device
    output logic             cfg_valid,
    output logic      [4:0]  cfg_index,
    output logic      [15:0] cfg_data,
    // Status
    output logic             load_done,
    output logic             mac_id_valid,
    // Clock output
    input  wire logic        clkout_enable,
    output logic             clock_output_pin
);

    localparam logic [4:0] LAST_IDX = 5'(`NVM_IDX_RED_BASE + RED_WORDS - 1);

    // ----------------------------------------
    // ECC check and zone decode
    // ----------------------------------------
    function automatic ecc_result_t ecc_check(input logic [21:0] cw);
        logic [4:0]  syn;
        logic        par;
        logic [21:0] fixed;
        int          k;
        ecc_result_t r;
        syn   = 5'h00;
        par   = ^cw;
        fixed = cw;
        k     = 0;
        r     = '0;
        for (int i = 1; i < `ECC_CW_BITS; i++) begin
            if (cw[i]) begin
                syn = syn ^ 5'(i);
            end
        end
        if (par && syn != 5'h00 && syn < 5'(`ECC_CW_BITS)) begin
            fixed[syn] = ~fixed[syn];
        end
        for (int i = 1; i < `ECC_CW_BITS; i++) begin
            if ((i & (i - 1)) != 0) begin
                r.data[k] = fixed[i];
                k = k + 1;
            end
        end
        r.single = par;
        r.double = !par && syn != 5'h00;
        return r;
    endfunction : ecc_check

    function automatic nvm_zone_t zone_of(input logic [4:0] idx);
        if (idx == `NVM_IDX_MAC_LOW || idx == `NVM_IDX_MAC_HIGH) begin
            return ZONE_YELLOW;
        end else if (idx == `NVM_IDX_WAFER) begin
            return ZONE_GREEN;
        end else begin
            return ZONE_RED;
        end
    endfunction : zone_of

    // ----------------------------------------
    // Load sequencer
    // ----------------------------------------
    // Memory is only ever read: no write port exists, so a bad word stays bad
    // and is merely reported each time it is loaded.
    load_state_t state;
    load_state_t next_state;
    logic [4:0]  idx;
    logic [15:0] mac_low;
    logic [15:0] mac_high;
    logic [15:0] wafer;
    logic [15:0] health;

    wire         cap      = ce && state == ST_DATA;
    ecc_result_t chk;
    nvm_zone_t   zone;
    logic [15:0] flag_set;

    assign chk  = ecc_check(nvm_cw);
    assign zone = zone_of(idx);

    assign nvm_rd   = state == ST_ADDR;
    assign nvm_addr = idx;

    always_comb begin
        next_state = state;
        case (state)
            ST_ADDR: next_state = ST_DATA;
            ST_DATA: next_state = (idx == LAST_IDX) ? ST_DONE : ST_ADDR;
            ST_DONE: next_state = ST_DONE;
            default: next_state = ST_ADDR;
        endcase
    end

    // Set terms per zone; nothing ever clears them but reset.
    always_comb begin
        flag_set = 16'h0000;
        if (cap) begin
            case (zone)
                ZONE_RED: begin
                    flag_set[`HB_RED_WARN]    = chk.single;
                    flag_set[`HB_RED_ERR]     = chk.double;
                end
                ZONE_YELLOW: begin
                    flag_set[`HB_YELLOW_WARN] = chk.single;
                    flag_set[`HB_YELLOW_ERR]  = chk.double;
                end
                ZONE_GREEN: begin
                    flag_set[`HB_GREEN_WARN]  = chk.single;
                    flag_set[`HB_GREEN_ERR]   = chk.double;
                end
                default: flag_set = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state  <= ST_ADDR;
            idx    <= `NVM_IDX_MAC_LOW;
            health <= `HEALTH_RESET;
        end else if (ce) begin
            state  <= next_state;
            health <= health | flag_set;
            if (state == ST_DATA && idx != LAST_IDX) begin
                idx <= idx + 5'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mac_low  <= `DATA_RESET;
            mac_high <= `DATA_RESET;
            wafer    <= `DATA_RESET;
        end else if (cap) begin
            if (idx == `NVM_IDX_MAC_LOW) begin
                mac_low <= chk.data;
            end
            if (idx == `NVM_IDX_MAC_HIGH) begin
                mac_high <= {8'h00, chk.data[7:0]};
            end
            if (idx == `NVM_IDX_WAFER) begin
                wafer <= {1'b0, chk.data[`WAFER_Y_MSB:`WAFER_Y_LSB],
                          1'b0, chk.data[`WAFER_X_MSB:`WAFER_X_LSB]};
            end
        end
    end

    // Red zone words go to the device configuration, already corrected.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_valid <= 1'b0;
            cfg_index <= 5'h00;
            cfg_data  <= `DATA_RESET;
        end else if (ce) begin
            cfg_valid <= cap && zone == ZONE_RED;
            if (cap && zone == ZONE_RED) begin
                cfg_index <= idx - `NVM_IDX_RED_BASE;
                cfg_data  <= chk.data;
            end
        end
    end

    assign load_done = state == ST_DONE;
    // Host builds the full address from the OUI and these 24 bits, then
    // fills its own filters; nothing here preloads a filter.
    assign mac_id_valid = load_done && !health[`HB_YELLOW_ERR];

    // ----------------------------------------
    // Register read port
    // ----------------------------------------
    wire hit_low    = reg_addr == `OFS_MAC_ADDRESS_LOW;
    wire hit_high   = reg_addr == `OFS_MAC_ADDRESS_HIGH;
    wire hit_wafer  = reg_addr == `OFS_DIE_WAFER_POSITION;
    wire hit_health = reg_addr == `OFS_CONFIG_MEMORY_HEALTH;
    wire hit_any    = hit_low || hit_high || hit_wafer || hit_health;

    // Reserved health bits 9:0 come back as zero.
    wire [15:0] rd_mux = hit_low    ? mac_low :
                         hit_high   ? mac_high :
                         hit_wafer  ? wafer :
                         hit_health ? {health[15:10], 10'h000} :
                                      16'h0000;

    // Read path only samples; no state changes on a read.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata  <= `DATA_RESET;
            reg_rvalid <= 1'b0;
            reg_err    <= 1'b0;
        end else if (ce) begin
            reg_rvalid <= reg_rd;
            reg_err    <= reg_rd && !hit_any;
            if (reg_rd) begin
                reg_rdata <= rd_mux;
            end
        end
    end

    // ----------------------------------------
    // Clock output
    // ----------------------------------------
    // Gated straight from the core clock: the only clock in this block.
    assign clock_output_pin = clkout_enable ? clk : 1'b0;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_yellow_double;
        cap && zone == ZONE_YELLOW && chk.double;
    endsequence

    sequence s_identity_lost;
        health[`HB_YELLOW_ERR] && !mac_id_valid;
    endsequence

    a_mac_low_read: assert property (@(posedge clk) disable iff (!arst_n)
        ce && reg_rd && hit_low |=> reg_rvalid && reg_rdata == $past(mac_low))
        else $error("low identifier read mismatch");

    a_mac_high_pad: assert property (@(posedge clk) disable iff (!arst_n)
        ce && reg_rd && hit_high |=> reg_rdata[15:8] == 8'h00)
        else $error("high identifier upper byte not zero");

    a_wafer_zero_bits: assert property (@(posedge clk) disable iff (!arst_n)
        wafer[15] == 1'b0 && wafer[7] == 1'b0)
        else $error("wafer position unused bits set");

    a_red_warn_set: assert property (@(posedge clk) disable iff (!arst_n)
        cap && zone == ZONE_RED && chk.single |=> health[`HB_RED_WARN])
        else $error("red warning not raised");

    a_red_err_set: assert property (@(posedge clk) disable iff (!arst_n)
        cap && zone == ZONE_RED && chk.double |=> health[`HB_RED_ERR])
        else $error("red error not raised");

    a_yellow_warn_set: assert property (@(posedge clk) disable iff (!arst_n)
        cap && zone == ZONE_YELLOW && chk.single |=> health[`HB_YELLOW_WARN])
        else $error("yellow warning not raised");

    a_green_warn_set: assert property (@(posedge clk) disable iff (!arst_n)
        cap && zone == ZONE_GREEN && chk.single |=> health[`HB_GREEN_WARN])
        else $error("green warning not raised");

    a_clkout_held_low: assert property (@(posedge clk) disable iff (!arst_n)
        !clkout_enable |-> !clock_output_pin)
        else $error("clock output not held low while disabled");

    a_yellow_err_id: assert property (@(posedge clk) disable iff (!arst_n)
        s_yellow_double |=> s_identity_lost)
        else $error("yellow error did not invalidate identifier");

    a_green_flags: assert property (@(posedge clk) disable iff (!arst_n)
        cap && zone == ZONE_GREEN |=>
            health[`HB_GREEN_ERR] == ($past(chk.double) || $past(health[`HB_GREEN_ERR])))
        else $error("green error flag wrong");

    a_flags_sticky: assert property (@(posedge clk) disable iff (!arst_n)
        (health & $past(health)) == $past(health))
        else $error("health flag cleared without reset");

    a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
        ce && reg_rd && hit_health |=> reg_rdata[9:0] == 10'h000)
        else $error("reserved health bits not zero");

endmodule : device_identity_config_memory_health_regs

`default_nettype wire

/* File: sim/device_identity_config_memory_health_regs_test.sv */
// Self-checking bench for the identity and configuration memory health bank.
// Assumes the bank's read port and a factory memory modelled here, one-cycle latency.
`timescale 1ns/1ps
`default_nettype none
`include "id_health_params.svh"

module device_identity_config_memory_health_regs_test import id_health_pkg::*;;
    localparam int RED_WORDS = 4;
    localparam int NWORDS    = 3 + RED_WORDS;

    logic        clk, arst_n, ce, reg_rd, clkout_enable, rd_q;
    logic [15:0] reg_addr, reg_rdata, cfg_data;
    logic        reg_rvalid, reg_err, nvm_rd, cfg_valid, load_done, mac_id_valid;
    logic        clock_output_pin;
    logic [4:0]  nvm_addr, cfg_index, idx_q;
    logic [21:0] nvm_cw = 22'h000000;
    logic [15:0] word [NWORDS];
    logic [21:0] flip [NWORDS];
    logic [5:0]  zone_err;
    int          seed = 87;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          cfg_seen = 0;

    device_identity_config_memory_health_regs #(.RED_WORDS(RED_WORDS)) dut (
        .clk(clk), .arst_n(arst_n), .ce(ce), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_err(reg_err),
        .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_cw(nvm_cw), .cfg_valid(cfg_valid),
        .cfg_index(cfg_index), .cfg_data(cfg_data), .load_done(load_done),
        .mac_id_valid(mac_id_valid), .clkout_enable(clkout_enable),
        .clock_output_pin(clock_output_pin));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [21:0] encode(input logic [15:0] d);
        logic [21:0] cw;
        int          k;
        cw = '0;
        k = 0;
        for (int p = 3; p < 22; p++) begin
            if ((p & (p - 1)) != 0) begin
                cw[p] = d[k];
                k++;
            end
        end
        for (int b = 1; b < 22; b = b * 2) begin
            for (int p = 3; p < 22; p++) begin
                if ((p & b) != 0 && (p & (p - 1)) != 0) cw[b] ^= cw[p];
            end
        end
        cw[0] = ^cw[21:1];
        return cw;
    endfunction : encode

    function automatic logic [21:0] bad(input logic dbl);
        int a;
        int b;
        a = {$random(seed)} % 22;
        b = (a + 1 + {$random(seed)} % 21) % 22;
        return (22'h000001 << a) | (dbl ? (22'h000001 << b) : 22'h000000);
    endfunction : bad

    function automatic logic [16:0] expect_reg(input logic [15:0] a);
        case (a)
            `OFS_MAC_ADDRESS_LOW:      return {1'b0, word[0]};
            `OFS_MAC_ADDRESS_HIGH:     return {9'h000, word[1][7:0]};
            `OFS_DIE_WAFER_POSITION:   return {1'b0, word[2] & 16'h7F7F};
            `OFS_CONFIG_MEMORY_HEALTH: return {1'b0, zone_err, 10'h000};
            default:                   return {1'b1, 16'h0000};
        endcase
    endfunction : expect_reg

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    // ----------------------------------------
    // Factory memory model and monitors
    // ----------------------------------------
    // Idle bus shows the inverse so a stale capture cannot pass
    always @(posedge clk) begin
        rd_q <= nvm_rd;
        idx_q <= nvm_addr;
    end
    always @(negedge clk) begin
        nvm_cw <= rd_q ? (encode(word[idx_q]) ^ flip[idx_q]) : ~nvm_cw;
    end
    always @(negedge clk) begin
        if (arst_n && cfg_valid) begin
            check("cfg_index", 16'(cfg_index), 16'(cfg_seen));
            if (!zone_err[4]) check("cfg_data", cfg_data, word[3 + cfg_seen]);
            cfg_seen++;
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            complete_run();
        end
    end

    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    task automatic rd(input logic [15:0] a);
        logic [16:0] e;
        logic [15:0] m;
        e = expect_reg(a);
        m = (a[15:1] == 15'h0801 && zone_err[2]) || (a == 16'h1004 && zone_err[0])
            ? 16'h0000 : 16'hFFFF;
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        check("reg_rvalid", 16'(reg_rvalid), 16'h0001);
        check("reg_err", 16'(reg_err), 16'(e[16]));
        check("reg_rdata", reg_rdata & m, e[15:0] & m);
    endtask : rd

    task automatic run(input logic [5:0] errs);
        zone_err = errs;
        arst_n = 1'b0;
        for (int i = 0; i < NWORDS; i++) begin
            word[i] = 16'($random(seed));
            flip[i] = '0;
        end
        if (errs[5] | errs[4]) flip[3 + {$random(seed)} % RED_WORDS] = bad(errs[4]);
        if (errs[3] | errs[2]) flip[{$random(seed)} % 2] = bad(errs[2]);
        if (errs[1] | errs[0]) flip[2] = bad(errs[0]);
        repeat (12) @(negedge clk);
        check("load_done_rst", 16'(load_done), 16'h0000);
        cfg_seen = 0;
        arst_n = 1'b1;
        for (int i = 0; i < 200 && load_done !== 1'b1; i++) @(negedge clk);
        check("load_done", 16'(load_done), 16'h0001);
        // Last red word's pulse shares this edge with load_done; let the monitor count it
        @(negedge clk);
        check("cfg_count", 16'(cfg_seen), 16'(RED_WORDS));
        check("mac_id_valid", 16'(mac_id_valid), 16'(!errs[2]));
        for (int r = 0; r < 2; r++) begin
            for (logic [15:0] a = 16'h1002; a <= 16'h1005; a++) rd(a);
        end
        rd(16'h1001);
        rd(16'h1006);
        rd(16'h0000);
        for (int i = 0; i < 20; i++) rd(16'h1000 + 16'({$random(seed)} % 8));
        reg_rd = 1'b0;
        @(negedge clk);
        check("rvalid_idle", 16'(reg_rvalid), 16'h0000);
        ce = 1'b0;
        reg_rd = 1'b1;
        repeat (2) @(negedge clk);
        check("rvalid_frozen", 16'(reg_rvalid), 16'h0000);
        ce = 1'b1;
        reg_rd = 1'b0;
    endtask : run

    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        clkout_enable = 1'b0;
        zone_err = 6'h00;
        @(posedge clk);
        #1;
        check("clkout_off", 16'(clock_output_pin), 16'h0000);
        @(negedge clk);
        clkout_enable = 1'b1;
        @(posedge clk);
        #1;
        check("clkout_high", 16'(clock_output_pin), 16'h0001);
        @(negedge clk);
        #1;
        check("clkout_low", 16'(clock_output_pin), 16'h0000);
        // Each zone sees both a corrected and an uncorrectable fault
        run(6'b000000);
        run(6'b101010);
        run(6'b010101);
        complete_run();
    end
endmodule : device_identity_config_memory_health_regs_test
`default_nettype wire
